// File: hw/xapd_exec.sv
`timescale 1ns/100ps
module xapd_exec import xapd_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire xapd_instr_type i_instr,
  input wire logic [7:0] i_acc,
  input wire logic [7:0] i_file_rdata,
  output logic [4:0] o_file_raddr,
  output xapd_wb_type o_wb,
  output logic o_done,
  output logic [23:0] o_port_dir
);
  // Decoded view of the presented word
  xapd_op_type op;
  logic [7:0] lit;
  logic [4:0] faddr;
  logic dest_file;
  logic [2:0] port_sel;
  logic is_lit;
  logic is_reg;
  logic is_dir_word;
  logic port_ok;

  // Shared operand and result path
  logic [7:0] operand;
  logic [7:0] xor_res;
  logic res_zero;

  // Accumulator write-back group
  logic acc_we_d;
  logic acc_we_q;
  logic [7:0] acc_data_d;
  logic [7:0] acc_data_q;

  // File register write-back group
  logic file_we_d;
  logic file_we_q;
  logic [4:0] file_addr_d;
  logic [4:0] file_addr_q;
  logic [7:0] file_data_d;
  logic [7:0] file_data_q;

  // Zero flag group
  logic zero_we_d;
  logic zero_we_q;
  logic zero_val_d;
  logic zero_val_q;

  // Completion and direction strobes
  logic done_d;
  logic done_q;
  logic [XAPD_PORT_CNT-1:0] dir_load;

  assign lit = i_instr.word[7:0];
  assign faddr = i_instr.word[XAPD_ADDR_W-1:0];
  assign dest_file = i_instr.word[XAPD_DEST_BIT];
  assign port_sel = i_instr.word[2:0];
  assign o_file_raddr = faddr;

  assign is_lit = (i_instr.word[11:8] == XAPD_LIT_OP);
  assign is_reg = (i_instr.word[11:6] == XAPD_REG_OP);
  assign is_dir_word = (i_instr.word[11:3] == XAPD_DIR_OP);
  // Ports below the first have no direction register, so such words stay undecoded
  assign port_ok = (port_sel >= XAPD_PORT_FIRST);

  // Literal first: its top nibble can never alias the other two classes
  always_comb begin
    op = XAPD_OP_NONE;
    if (i_instr.valid) begin
      if (is_lit) begin
        op = XAPD_OP_XLIT;
      end else if (is_reg) begin
        op = XAPD_OP_XREG;
      end else if (is_dir_word && port_ok) begin
        op = XAPD_OP_DIR;
      end
    end
  end

  // File operand is read combinationally so the whole op fits one cycle
  always_comb begin
    operand = i_file_rdata;
    if (op == XAPD_OP_XLIT) begin
      operand = lit;
    end
  end

  assign xor_res = i_acc ^ operand;
  assign res_zero = (xor_res == 8'h00);

  // Accumulator takes the literal result, or the register result unless routed back
  always_comb begin
    acc_we_d = 1'b0;
    acc_data_d = 8'h00;
    unique case (op)
      XAPD_OP_XLIT: begin
        acc_we_d = 1'b1;
        acc_data_d = xor_res;
      end
      XAPD_OP_XREG: begin
        acc_we_d = !dest_file;
        acc_data_d = xor_res;
      end
      XAPD_OP_DIR: begin
        acc_we_d = 1'b0;
      end
      XAPD_OP_NONE: begin
        acc_we_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc_we_q <= 1'b0;
      acc_data_q <= 8'h00;
    end else begin
      acc_we_q <= acc_we_d;
      acc_data_q <= acc_data_d;
    end
  end

  // Address and data are zeroed unless the op is a register XOR, even one whose result goes to the accumulator
  always_comb begin
    file_we_d = 1'b0;
    file_addr_d = 5'h00;
    file_data_d = 8'h00;
    if (op == XAPD_OP_XREG) begin
      file_we_d = dest_file;
      file_addr_d = faddr;
      file_data_d = xor_res;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      file_we_q <= 1'b0;
      file_addr_q <= 5'h00;
      file_data_q <= 8'h00;
    end else begin
      file_we_q <= file_we_d;
      file_addr_q <= file_addr_d;
      file_data_q <= file_data_d;
    end
  end

  // Direction loads leave every flag alone
  always_comb begin
    zero_we_d = 1'b0;
    zero_val_d = 1'b0;
    unique case (op)
      XAPD_OP_XLIT, XAPD_OP_XREG: begin
        zero_we_d = 1'b1;
        zero_val_d = res_zero;
      end
      XAPD_OP_DIR: begin
        zero_we_d = 1'b0;
      end
      XAPD_OP_NONE: begin
        zero_we_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      zero_we_q <= 1'b0;
      zero_val_q <= 1'b0;
    end else begin
      zero_we_q <= zero_we_d;
      zero_val_q <= zero_val_d;
    end
  end

  // Every recognised op finishes in the cycle after it is taken
  always_comb begin
    done_d = (op != XAPD_OP_NONE);
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      done_q <= 1'b0;
    end else begin
      done_q <= done_d;
    end
  end

  // Write-back leaves as one word so the core applies it in the same cycle
  always_comb begin
    o_wb.acc_we = acc_we_q;
    o_wb.acc_data = acc_data_q;
    o_wb.file_we = file_we_q;
    o_wb.file_addr = file_addr_q;
    o_wb.file_data = file_data_q;
    o_wb.zero_we = zero_we_q;
    o_wb.zero_val = zero_val_q;
  end

  assign o_done = done_q;

  // One-hot load strobe; the port selects are distinct so at most one bit rises
  always_comb begin
    dir_load = '0;
    for (int p = 0; p < XAPD_PORT_CNT; p++) begin
      if (op == XAPD_OP_DIR && port_sel == XAPD_PORT_FIRST + 3'(p)) begin
        dir_load[p] = 1'b1;
      end
    end
  end

  // Reset value and storage live in the small register module
  genvar g;
  generate
    for (g = 0; g < XAPD_PORT_CNT; g++) begin : g_port
      xapd_dir_reg u_dir (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_load(dir_load[g]),
        .i_data(i_acc),
        .o_dir(o_port_dir[g*8 +: 8])
      );
    end
  endgenerate
endmodule // xapd_exec

// File: hw/xapd_pkg.sv
package xapd_pkg;
  localparam int XAPD_OP_W = 12;
  localparam int XAPD_DATA_W = 8;
  localparam int XAPD_ADDR_W = 5;
  localparam logic [3:0] XAPD_LIT_OP = 4'hF;
  localparam logic [5:0] XAPD_REG_OP = 6'h06;
  localparam logic [8:0] XAPD_DIR_OP = 9'h000;
  localparam logic [2:0] XAPD_PORT_FIRST = 3'h5;
  localparam int XAPD_PORT_CNT = 3;
  localparam logic [7:0] XAPD_DIR_RESET = 8'hFF;
  localparam int XAPD_DEST_BIT = 5;

  typedef enum logic [1:0] {
    XAPD_OP_NONE = 2'h0,
    XAPD_OP_DIR = 2'h1,
    XAPD_OP_XLIT = 2'h2,
    XAPD_OP_XREG = 2'h3
  } xapd_op_type;

  typedef struct packed {
    logic valid;
    logic [11:0] word;
  } xapd_instr_type;

  typedef struct packed {
    logic acc_we;
    logic [7:0] acc_data;
    logic file_we;
    logic [4:0] file_addr;
    logic [7:0] file_data;
    logic zero_we;
    logic zero_val;
  } xapd_wb_type;
endpackage

// File: hw/xapd_dir_reg.sv
`timescale 1ns/100ps
module xapd_dir_reg import xapd_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_load,
  input wire logic [7:0] i_data,
  output logic [7:0] o_dir
);
  logic [7:0] dir_d;
  logic [7:0] dir_q;

  always_comb begin
    dir_d = i_load ? i_data : dir_q;
  end

  // Reset leaves every pin an input so nothing is driven before software decides
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dir_q <= XAPD_DIR_RESET;
    end else begin
      dir_q <= dir_d;
    end
  end

  assign o_dir = dir_q;
endmodule // xapd_dir_reg

// File: verification/xapd_chk.sv
`timescale 1ns/100ps
module xapd_chk import xapd_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire xapd_instr_type i_instr,
  input wire logic [7:0] i_acc,
  input wire logic [7:0] i_file_rdata,
  input wire xapd_wb_type o_wb,
  input wire logic o_done,
  input wire logic [23:0] o_port_dir
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  a_dir_flags: assert property (i_instr.valid && i_instr.word == 12'h005 |=> o_done && !o_wb.zero_we)
    else $error("dir load");
  a_lit_xor: assert property (i_instr.valid && i_instr.word[11:8] == 4'hF |=> o_wb.acc_we
    && o_wb.acc_data == ($past(i_acc) ^ $past(i_instr.word[7:0]))) else $error("lit xor");
  a_reg_xor: assert property (i_instr.valid && i_instr.word[11:6] == 6'h06 |=> o_done && o_wb.zero_we)
    else $error("reg xor");
  a_dest_sel: assert property (i_instr.valid && i_instr.word[11:6] == 6'h06 |=>
    o_wb.file_we == $past(i_instr.word[5]) && o_wb.acc_we != o_wb.file_we) else $error("dest");
  a_zero_val: assert property (o_wb.zero_we |->
    o_wb.zero_val == ((o_wb.acc_we ? o_wb.acc_data : o_wb.file_data) == 8'h00)) else $error("zero");
  a_dir_hold: assert property (!(i_instr.valid && i_instr.word[11:3] == 9'h000 && i_instr.word[2:0] >= 3'h5)
    |=> $stable(o_port_dir)) else $error("dir hold");
  a_dir_load: assert property (i_instr.valid && i_instr.word == 12'h006 |=>
    o_port_dir[15:8] == $past(i_acc)) else $error("dir load value");
endmodule // xapd_chk

// File: verification/xapd_tb.sv
`timescale 1ns/100ps
module xapd_tb import xapd_pkg::*; ;
  logic i_sys_clk = 1'h0;
  logic i_rst_n = 1'h0;
  xapd_instr_type ins = '0;
  logic [7:0] acc = 8'h00;
  logic [7:0] rd = 8'h00;
  xapd_wb_type wb;
  logic done;
  logic [23:0] pd;
  logic [4:0] ra;
  logic [4:0] ra_seen = 5'h00;
  int err_count = 0;
  int checked = 0;
  int cyc = 0;
  always #50 i_sys_clk = ~i_sys_clk;
  xapd_exec u_dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_instr(ins), .i_acc(acc), .i_file_rdata(rd),
    .o_file_raddr(ra), .o_wb(wb), .o_done(done), .o_port_dir(pd));
  task automatic final_report();
    if (err_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  // Word is dropped after one edge so every op is a single-cycle pulse
  task automatic op(input logic [11:0] w, input logic [7:0] a, input logic [7:0] r);
    @(posedge i_sys_clk);
    ins <= {1'h1, w};
    acc <= a;
    rd <= r;
    #1;
    ra_seen = ra;
    @(posedge i_sys_clk);
    ins <= '0;
    #1;
  endtask
  task automatic t_dir();
    for (int p = 4; p < 8; p++) begin
      op(12'(p), 8'(8'h30 + p), 8'h00);
      chk("done", 24'(p > 4), 24'(done));
    end
    chk("dir", 24'h373635, pd);
  endtask
  task automatic t_xor();
    op(12'hFAF, 8'hB5, 8'h00);
    chk("lit", 24'h51A, {wb.file_we, wb.zero_we, wb.zero_val, wb.acc_we, wb.acc_data});
    op(12'hF5A, 8'h5A, 8'h00);
    chk("litz", 24'h700, {wb.file_we, wb.zero_we, wb.zero_val, wb.acc_we, wb.acc_data});
    op(12'h1BF, 8'hB5, 8'hAF);
    chk("regf", 24'h5F1A, {wb.file_we, wb.acc_we, wb.file_addr, wb.file_data});
    chk("raddr", 32'h1F, 32'(ra_seen));
    chk("rdone", 32'h1, 32'(done));
    op(12'h180, 8'h3C, 8'h3C);
    chk("rega", 24'h300, {wb.file_we, wb.acc_we, wb.zero_val, wb.acc_data});
    @(posedge i_sys_clk);
    #1;
    chk("drop", 32'h0, 32'({done, wb}));
  endtask
  task automatic t_rst();
    op(12'h006, 8'h42, 8'h00);
    chk("dir6", 32'h374235, 32'(pd));
    @(posedge i_sys_clk);
    i_rst_n <= 1'h0;
    repeat (2) @(posedge i_sys_clk);
    chk("rstdir", 32'hFFFFFF, 32'(pd));
    chk("rstwb", 32'h0, 32'({done, wb}));
    i_rst_n <= 1'h1;
    op(12'hF0F, 8'hF0, 8'h00);
    chk("post", 32'h3FF, 32'({done, wb.acc_we, wb.acc_data}));
  endtask
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 500) begin
      err_count++;
      final_report();
    end
  end
  initial begin
    repeat (10) @(posedge i_sys_clk);
    chk("rst", 24'hFFFFFF, pd);
    i_rst_n <= 1'h1;
    t_dir();
    t_xor();
    t_rst();
    final_report();
  end
endmodule // xapd_tb
bind xapd_exec xapd_chk u_chk (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_instr(i_instr), .i_acc(i_acc),
  .i_file_rdata(i_file_rdata), .o_wb(o_wb), .o_done(o_done), .o_port_dir(o_port_dir));
